// ==== opsl_pkg.sv ====
/*
  Package for the output port and strobe logic: timing counts, mode
  encodings, reset values and the carrier structs shared by the design.
  Assumes a 125 MHz system clock from which bus-phase events are
  supplied as one-cycle qualifier pulses by the surrounding core.
*/
// Functional notes
// RQ1: Eight port pins are always outputs, no direction control in any mode.
// RQ2: Expanded modes pass port accesses to the external bus, not handled internally.
// RQ3: External logic must emulate port and strobe functions in expanded modes.
// RQ4: Single-chip read returns the latched output value, not pin levels.
// RQ5: No internal port read enable for port accesses in expanded modes.
// RQ6: Single-chip port write loads internal bus data into the port latch.
// RQ7: Reset in single-chip mode drives every port pin low.
// RQ8: Expanded mode passes high address while strobe high, holds while low.
// RQ9: Port pins change at the falling edge of the second phase clock.
// RQ10: Port value never changes in the same bus cycle as its read.
// RQ11: High address stays valid one eighth cycle after bus clock falls.
// RQ12: Expanded mode shared pin outputs read/write through an address-strobe latch.
// RQ13: Single-chip mode shared pin outputs the handshake output strobe.
// RQ14: Strobe active low with polarity bit 0, active high with 1.
// RQ15: Handshake 0 gives simple strobe; 1/1 full output; 1/0 full input.
// RQ16: Simple strobe begins at phase-two rise after an output port write.
// RQ17: Full-input strobe begins at phase-two rise after latched input read.
// RQ18: Full-output strobe begins at phase-two rise after latched port write.
// RQ19: Simple or pulsed strobe ends exactly two bus clock periods after start.
// RQ20: Interlocked strobe ends at phase-two rise after active input strobe edge.
// RQ21: Setting pulsed bit while handshaking ends an active strobe at next rise.
// RQ22: Strobe holds active from start until an end condition, then inactive.
package opsl_pkg;

  // -----------------------------------------------------------------
  // Widths and reset values
  // -----------------------------------------------------------------
  localparam int          OPSL_PORT_W      = 8;
  localparam logic [7:0]  OPSL_PORT_RST    = 8'h00;
  localparam logic [1:0]  OPSL_BUS_PERIODS = 2'h2;   // Pulsed strobe length in bus periods

  // -----------------------------------------------------------------
  // Strobe modes and state
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    OPSL_MODE_SIMPLE   = 2'h0,
    OPSL_MODE_FULL_IN  = 2'h1,
    OPSL_MODE_FULL_OUT = 2'h3
  } opsl_mode_t;

  typedef enum logic [1:0] {
    OPSL_ST_IDLE   = 2'h0,
    OPSL_ST_ARMED  = 2'h1,
    OPSL_ST_ACTIVE = 2'h3
  } opsl_state_t;

  // Handshake control bits
  typedef struct packed {
    logic handshake_enable;
    logic direction_select;
    logic pulsed_strobe_select;
    logic strobe_polarity_invert;
    logic input_edge_rising;
  } opsl_ctrl_t;

  // Bus phase qualifiers, one-cycle pulses in the clk domain
  typedef struct packed {
    logic ph2_rise;
    logic ph2_fall;
    logic e_fall;
    logic addr_latch_strobe;
  } opsl_phase_t;

endpackage : opsl_pkg

// ==== opsl_port.sv ====
/*
  Output port latch, shared read/write or strobe pin and the handshake
  strobe sequencer. All timing is expressed as qualifier pulses on clk;
  the core supplies phase events, access decodes and control bits on the
  same clock. The handshake input strobe arrives from a pin and is
  synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module opsl_port
  import opsl_pkg::*;
#(
  parameter int PORT_W = OPSL_PORT_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Mode and control
  input  wire logic              expanded_mode_select,
  input  wire opsl_ctrl_t        ctrl,
  input  wire logic              ctrl_write,
  input  wire opsl_phase_t       phase,
  // Internal access decodes
  input  wire logic              port_access_read,
  input  wire logic              port_access_write,
  input  wire logic              latched_input_read,
  input  wire logic              latched_port_write,
  input  wire logic [PORT_W-1:0] wdata,
  input  wire logic [PORT_W-1:0] high_address,
  input  wire logic              bus_read_write,
  // Core side results
  output logic                   port_read_enable,
  output logic                   port_external_access,
  output logic [PORT_W-1:0]      port_rdata,
  // Pins
  input  wire logic              handshake_input_strobe,
  output logic [PORT_W-1:0]      port_pins,
  output logic                   rw_strobe_pin
);

  // -----------------------------------------------------------------
  // Parameter check
  // -----------------------------------------------------------------
  if (PORT_W != OPSL_PORT_W) begin : g_bad_w
    $error("opsl_port: port width must be eight");
  end

  // -----------------------------------------------------------------
  // Port latch
  // -----------------------------------------------------------------
  logic [PORT_W-1:0] half_latch_ff, nxt_half_latch;
  logic [PORT_W-1:0] pend_data_ff, nxt_pend_data;
  logic              pend_ff, nxt_pend;
  logic              rw_latch_ff, nxt_rw_latch;
  logic [PORT_W-1:0] nxt_port_rdata;
  logic              port_write_pulse;

  // Writes only count in single-chip mode; in expanded mode they go out
  assign port_write_pulse     = port_access_write & ~expanded_mode_select; // RQ2
  assign port_read_enable     = port_access_read & ~expanded_mode_select;  // RQ5
  assign port_external_access = (port_access_read | port_access_write) & expanded_mode_select; // RQ2

  // Write data waits for phase-two fall, so a read earlier in the cycle sees the old value
  always_comb begin
    nxt_half_latch = half_latch_ff;
    nxt_pend_data  = pend_data_ff;
    nxt_pend       = pend_ff;
    nxt_rw_latch   = rw_latch_ff;
    if (expanded_mode_select) begin
      nxt_pend = 1'b0;
      // Transparent while the address strobe is high, held while low
      if (phase.addr_latch_strobe) begin
        nxt_half_latch = high_address; // RQ8 RQ11
        nxt_rw_latch   = bus_read_write; // RQ12
      end
    end else begin
      if (port_write_pulse) begin
        nxt_pend_data = wdata; // RQ6
        nxt_pend      = 1'b1;
      end
      if (pend_ff && phase.ph2_fall) begin
        nxt_half_latch = pend_data_ff; // RQ9 RQ10
        nxt_pend       = port_write_pulse;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      half_latch_ff <= PORT_W'(OPSL_PORT_RST); // RQ7
      pend_data_ff  <= PORT_W'(OPSL_PORT_RST);
      pend_ff       <= 1'b0;
      rw_latch_ff   <= 1'b1;
    end else begin
      half_latch_ff <= nxt_half_latch;
      pend_data_ff  <= nxt_pend_data;
      pend_ff       <= nxt_pend;
      rw_latch_ff   <= nxt_rw_latch;
    end
  end

  // Pins are always driven; no direction control exists
  assign port_pins  = half_latch_ff; // RQ1
  // Readback comes from the latch, never from the pins; zero outside a read
  always_comb begin
    nxt_port_rdata = port_read_enable ? half_latch_ff : PORT_W'(OPSL_PORT_RST); // RQ4
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      port_rdata <= PORT_W'(OPSL_PORT_RST);
    end else begin
      port_rdata <= nxt_port_rdata;
    end
  end

  // -----------------------------------------------------------------
  // Input strobe synchroniser: three flops, second and third agree
  // -----------------------------------------------------------------
  logic [2:0] sync_ff, nxt_sync;
  logic       in_level_ff, nxt_in_level;
  logic       in_edge;

  // Only the last two stages decide, so a metastable first stage never leaks out
  always_comb begin
    nxt_sync     = {sync_ff[1:0], handshake_input_strobe};
    nxt_in_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : in_level_ff;
  end

  // Only a transition toward the selected level counts as an active edge
  assign in_edge = (nxt_in_level != in_level_ff) && (nxt_in_level == ctrl.input_edge_rising);

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_ff     <= 3'h0;
      in_level_ff <= 1'b0;
    end else begin
      sync_ff     <= nxt_sync;
      in_level_ff <= nxt_in_level;
    end
  end

  // -----------------------------------------------------------------
  // Strobe sequencer
  // -----------------------------------------------------------------
  opsl_state_t state_ff, nxt_state;
  opsl_mode_t  mode;
  logic [1:0]  per_cnt_ff, nxt_per_cnt;
  logic        seen_edge_ff, nxt_seen_edge;
  logic        early_end_ff, nxt_early_end;
  logic        start_req;
  logic        pulsed;
  logic        strobe_active;

  // Handshake off ignores the direction bit
  always_comb begin
    if (!ctrl.handshake_enable) begin
      mode = OPSL_MODE_SIMPLE; // RQ15
    end else if (ctrl.direction_select) begin
      mode = OPSL_MODE_FULL_OUT;
    end else begin
      mode = OPSL_MODE_FULL_IN;
    end
  end

  always_comb begin
    case (mode)
      OPSL_MODE_SIMPLE:   start_req = port_write_pulse; // RQ16
      OPSL_MODE_FULL_IN:  start_req = latched_input_read; // RQ17
      OPSL_MODE_FULL_OUT: start_req = latched_port_write; // RQ18
      default:            start_req = 1'b0;
    endcase
  end

  // Simple strobe is always pulsed, whatever the pulsed bit says
  assign pulsed = ~ctrl.handshake_enable | ctrl.pulsed_strobe_select;

  // Armed waits for the phase-two rise; active counts bus periods or waits on the input edge
  always_comb begin
    nxt_state     = state_ff;
    nxt_per_cnt   = per_cnt_ff;
    nxt_seen_edge = seen_edge_ff;
    nxt_early_end = early_end_ff;
    case (state_ff)
      OPSL_ST_IDLE: begin
        if (start_req) begin
          nxt_state = OPSL_ST_ARMED;
        end
      end
      OPSL_ST_ARMED: begin
        if (phase.ph2_rise) begin
          nxt_state     = OPSL_ST_ACTIVE;
          nxt_per_cnt   = 2'h0;
          // Clearing here drops a stale input edge left from an earlier strobe
          nxt_seen_edge = 1'b0;
          nxt_early_end = 1'b0;
        end
      end
      OPSL_ST_ACTIVE: begin
        if (in_edge) begin
          nxt_seen_edge = 1'b1;
        end
        // A late switch to pulsed must not leave an interlocked strobe hanging
        if (ctrl_write && ctrl.handshake_enable && ctrl.pulsed_strobe_select) begin
          nxt_early_end = 1'b1; // RQ21
        end
        if (phase.ph2_rise) begin
          nxt_per_cnt = per_cnt_ff + 2'h1;
          if ((pulsed && (per_cnt_ff + 2'h1 == OPSL_BUS_PERIODS)) || early_end_ff ||
              (!pulsed && seen_edge_ff)) begin
            nxt_state = start_req ? OPSL_ST_ARMED : OPSL_ST_IDLE; // RQ19 RQ20 RQ22
          end
        end
      end
      default: nxt_state = OPSL_ST_IDLE;
    endcase
    // Leaving single-chip mode abandons any strobe in flight
    if (expanded_mode_select) begin
      nxt_state = OPSL_ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff     <= OPSL_ST_IDLE;
      per_cnt_ff   <= 2'h0;
      seen_edge_ff <= 1'b0;
      early_end_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      per_cnt_ff   <= nxt_per_cnt;
      seen_edge_ff <= nxt_seen_edge;
      early_end_ff <= nxt_early_end;
    end
  end

  // Only the active state drives the strobe; armed still shows the idle level
  assign strobe_active = (state_ff == OPSL_ST_ACTIVE);

  // Shared pin: read/write latch in expanded mode, polarity-steered strobe otherwise
  assign rw_strobe_pin = expanded_mode_select ? rw_latch_ff   // RQ12
                       : (strobe_active ~^ ctrl.strobe_polarity_invert); // RQ13 RQ14

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  AST_NO_READ_EXP: assert property (@(posedge clk) disable iff (reset) // RQ5
    expanded_mode_select |-> !port_read_enable) else $error("port read enable in expanded mode");
  AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (reset) // RQ6
    (pend_ff && phase.ph2_fall && !expanded_mode_select) |=> port_pins == $past(pend_data_ff))
    else $error("port write did not reach pins");
  AST_STABLE_NO_FALL: assert property (@(posedge clk) disable iff (reset) // RQ9
    (!expanded_mode_select && !phase.ph2_fall && !$past(expanded_mode_select)) |=> $stable(port_pins))
    else $error("port pins changed away from phase-two fall");
  AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (reset) // RQ8
    (expanded_mode_select && !phase.addr_latch_strobe) |=> $stable(port_pins))
    else $error("address changed while strobe low");
  AST_RW_PASS: assert property (@(posedge clk) disable iff (reset) // RQ12
    (expanded_mode_select && phase.addr_latch_strobe) |=> rw_strobe_pin == $past(bus_read_write))
    else $error("read/write not passed through latch");
  AST_POLARITY: assert property (@(posedge clk) disable iff (reset) // RQ14
    (!expanded_mode_select && !strobe_active) |-> rw_strobe_pin == ~ctrl.strobe_polarity_invert)
    else $error("inactive strobe level wrong");
  AST_START_RISE: assert property (@(posedge clk) disable iff (reset) // RQ16
    (state_ff == OPSL_ST_ARMED && phase.ph2_rise && !expanded_mode_select) |=> strobe_active)
    else $error("strobe did not start at phase-two rise");
  AST_ACTIVE_ON_RISE: assert property (@(posedge clk) disable iff (reset) // RQ22
    (!strobe_active ##1 strobe_active) |-> $past(phase.ph2_rise))
    else $error("strobe began away from phase-two rise");
  AST_PULSE_LEN: assert property (@(posedge clk) disable iff (reset) // RQ19
    (strobe_active && pulsed && phase.ph2_rise && per_cnt_ff == 2'h1 && !expanded_mode_select)
    |=> !strobe_active || state_ff == OPSL_ST_ARMED) else $error("pulsed strobe length wrong");
  AST_EARLY_END: assert property (@(posedge clk) disable iff (reset) // RQ21
    (strobe_active && early_end_ff && phase.ph2_rise) |=> !strobe_active)
    else $error("strobe not ended after pulsed bit set");
  // Interlocked end waits for a synchronised input edge, or for an early end after a pulsed-bit write
  AST_INTERLOCK_END: assert property (@(posedge clk) disable iff (reset) // RQ20
    (strobe_active && !pulsed && seen_edge_ff && phase.ph2_rise) |=> !strobe_active)
    else $error("interlocked strobe not ended after input edge");
  // Start conditions of the two full handshake modes
  AST_FULL_IN_START: assert property (@(posedge clk) disable iff (reset) // RQ17
    (state_ff == OPSL_ST_IDLE && mode == OPSL_MODE_FULL_IN && latched_input_read && !expanded_mode_select)
    |=> state_ff == OPSL_ST_ARMED) else $error("full-input strobe not armed by latched read");
  AST_FULL_OUT_START: assert property (@(posedge clk) disable iff (reset) // RQ18
    (state_ff == OPSL_ST_IDLE && mode == OPSL_MODE_FULL_OUT && latched_port_write && !expanded_mode_select)
    |=> state_ff == OPSL_ST_ARMED) else $error("full-output strobe not armed by latched write");
  // Reset and readback; the reset check stays live while reset is high
  AST_RESET_LOW: assert property (@(posedge clk) // RQ7
    reset |=> port_pins == PORT_W'(OPSL_PORT_RST)) else $error("port pins not low after reset");
  AST_READ_LATCH: assert property (@(posedge clk) disable iff (reset) // RQ4
    port_read_enable |=> port_rdata == $past(port_pins)) else $error("readback differs from latch");

  // -----------------------------------------------------------------
  // Cover points
  // -----------------------------------------------------------------
  COV_SIMPLE: cover property (@(posedge clk) disable iff (reset) strobe_active && mode == OPSL_MODE_SIMPLE);
  COV_FULL_IN: cover property (@(posedge clk) disable iff (reset) strobe_active && mode == OPSL_MODE_FULL_IN);
  COV_INTERLOCK: cover property (@(posedge clk) disable iff (reset) strobe_active && seen_edge_ff);
  COV_EXPANDED: cover property (@(posedge clk) disable iff (reset) expanded_mode_select && phase.addr_latch_strobe);
  COV_EARLY_END: cover property (@(posedge clk) disable iff (reset) strobe_active && early_end_ff);

endmodule : opsl_port
`default_nettype wire

// ==== opsl_peer.sv ====
/*
  Far-side peripheral model: answers the handshake output strobe with
  an active edge on the handshake input strobe after a set delay.
  Assumes it shares clk with the port logic.
*/
`timescale 1ns/1ps
`default_nettype none
module opsl_peer (
  // Clock
  input  wire logic       clk,
  // Setup from the bench
  input  wire logic       answer_en,
  input  wire logic       edge_rising,
  input  wire logic       active_high,
  input  wire logic [7:0] answer_delay,
  // Pins
  input  wire logic       strobe_pin,
  output logic            input_strobe
);
  logic [7:0] wait_ff  = 8'h00;
  logic       level_ff = 1'b0;

  // Answer late on purpose so a strobe ended too early shows up
  always @(posedge clk) begin
    if (answer_en && (strobe_pin === active_high)) begin
      wait_ff <= wait_ff + 8'h01;
      if (wait_ff == answer_delay) level_ff <= 1'b1;
    end else begin
      wait_ff  <= 8'h00;
      level_ff <= 1'b0;
    end
  end

  // Idle level is the inverse of the active edge
  assign input_strobe = level_ff ~^ edge_rising;
endmodule : opsl_peer
`default_nettype wire

// ==== tb_output_port_and_strobe_logic.sv ====
/*
  Bench for the output port and strobe logic: port writes and reads,
  strobe modes against the peer model, expanded address latching.
  Assumes opsl_pkg, opsl_port and opsl_peer are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_output_port_and_strobe_logic;
  import opsl_pkg::*;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic        clk = 1'b0, reset = 1'b1, expanded_mode_select = 1'b0;
  logic        ctrl_write = 1'b0, bus_read_write = 1'b1, peer_en = 1'b0;
  opsl_ctrl_t  ctrl = opsl_ctrl_t'(5'h01);
  opsl_phase_t phase = '0;
  logic [3:0]  acc = 4'h0;
  logic [7:0]  wdata = 8'h00, high_address = 8'h00, port_rdata, port_pins, prev, rdata_seen;
  logic [1:0]  cnt = 2'h0;
  logic        port_read_enable, port_external_access, handshake_input_strobe, rw_strobe_pin;
  logic        last_fall = 1'b0, ext_seen, rden_seen;
  logic [4:0]  modes [6] = '{5'h01, 5'h0B, 5'h15, 5'h1E, 5'h19, 5'h12};
  logic [3:0]  sels [6] = '{4'h4, 4'h4, 4'h2, 4'h1, 4'h1, 4'h2};
  int          i, st, len, cycles = 0, bad_count = 0, tests_run = 0;

  always #4 clk = ~clk;

  opsl_port i_dut (.clk(clk), .reset(reset), .expanded_mode_select(expanded_mode_select),
    .ctrl(ctrl), .ctrl_write(ctrl_write), .phase(phase), .port_access_read(acc[3]),
    .port_access_write(acc[2]), .latched_input_read(acc[1]), .latched_port_write(acc[0]),
    .wdata(wdata), .high_address(high_address), .bus_read_write(bus_read_write),
    .port_read_enable(port_read_enable), .port_external_access(port_external_access),
    .port_rdata(port_rdata), .handshake_input_strobe(handshake_input_strobe),
    .port_pins(port_pins), .rw_strobe_pin(rw_strobe_pin));

  opsl_peer i_peer (.clk(clk), .answer_en(peer_en), .edge_rising(ctrl.input_edge_rising),
    .active_high(ctrl.strobe_polarity_invert), .answer_delay(8'h14),
    .strobe_pin(rw_strobe_pin), .input_strobe(handshake_input_strobe));

  // Bus period of four clocks; timeout cuts a hang short
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    phase <= '{ph2_rise: cnt == 2'h3, ph2_fall: cnt == 2'h1, e_fall: cnt == 2'h0,
               addr_latch_strobe: cnt == 2'h2};
    last_fall <= phase.ph2_fall;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check1

  // One-cycle access pulse; read results captured where they stand
  task automatic access(input logic [3:0] sel, input logic [7:0] d);
    @(posedge clk);
    acc <= sel;
    wdata <= d;
    @(negedge clk);
    ext_seen = port_external_access;
    rden_seen = port_read_enable;
    @(posedge clk);
    acc <= 4'h0;
    @(negedge clk);
    rdata_seen = port_rdata;
  endtask : access

  task automatic set_ctrl(input opsl_ctrl_t c);
    @(posedge clk);
    ctrl <= c;
    ctrl_write <= 1'b1;
    @(posedge clk);
    ctrl_write <= 1'b0;
    @(negedge clk);
  endtask : set_ctrl

  // Counts cycles until the strobe reaches the asked activity, bounded
  task automatic wait_pin(input logic act, output int n);
    n = 0;
    while (((rw_strobe_pin === ctrl.strobe_polarity_invert) != act) && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_pin

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // -------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check8("pins after reset", 8'h00, port_pins);
    check1("strobe idle", 1'b1, rw_strobe_pin);
    access(4'h4, 8'hA5);
    for (i = 0; i < 8; i++) begin
      prev = port_pins;
      @(negedge clk);
      if (port_pins !== prev) check1("change after phase fall", 1'b1, last_fall);
    end
    check8("pins after write", 8'hA5, port_pins);
    wait_pin(1'b0, len);
    access(4'h8, 8'h00);
    check1("read enable", 1'b1, rden_seen);
    check8("read data", 8'hA5, rdata_seen);
    check8("pins over read", 8'hA5, port_pins);
    // Pulsed strobes in every mode, then interlocked against the peer
    peer_en <= 1'b1;
    for (i = 0; i < 6; i++) begin
      set_ctrl(opsl_ctrl_t'(modes[i]));
      repeat (4) @(posedge clk);
      access(sels[i], 8'h5A);
      wait_pin(1'b1, st);
      wait_pin(1'b0, len);
      check1("start after phase rise", 1'b1, st <= 6);
      if (i < 4) check8("pulsed length", 8'h08, len[7:0]);
      else check1("interlocked end", 1'b1, len >= 21 && len <= 32);
    end
    // Pulsed bit written while an interlocked strobe waits
    peer_en <= 1'b0;
    set_ctrl(opsl_ctrl_t'(5'h19));
    access(4'h1, 8'h00);
    wait_pin(1'b1, st);
    repeat (10) @(negedge clk);
    check1("strobe holds", 1'b0, rw_strobe_pin);
    set_ctrl(opsl_ctrl_t'(5'h1D));
    wait_pin(1'b0, len);
    check1("pulsed write ends strobe", 1'b1, len <= 6);
    // Expanded mode address and read/write latching
    @(posedge clk);
    expanded_mode_select <= 1'b1;
    high_address <= 8'h3C;
    bus_read_write <= 1'b0;
    repeat (6) @(negedge clk);
    check8("address on pins", 8'h3C, port_pins);
    check1("read/write pin", 1'b0, rw_strobe_pin);
    while (phase.addr_latch_strobe !== 1'b1) @(negedge clk);
    @(posedge clk);
    high_address <= 8'hC3;
    bus_read_write <= 1'b1;
    repeat (2) @(negedge clk);
    check8("address held", 8'h3C, port_pins);
    repeat (4) @(negedge clk);
    check8("next address", 8'hC3, port_pins);
    check1("read/write follows", 1'b1, rw_strobe_pin);
    access(4'h4, 8'h77);
    check1("write external", 1'b1, ext_seen);
    access(4'h8, 8'h00);
    check1("no read enable", 1'b0, rden_seen);
    check8("pins keep address", 8'hC3, port_pins);
    complete_run();
  end
endmodule : tb_output_port_and_strobe_logic
`default_nettype wire
